/* File: rtl/sct_pkg.sv */
// Function
// R1: plain commands interleave; transported commands never nest
// R2: no-data commands interleave without ordering limits
// R3: host completes data phase before next command
// R4: plain reads/writes may sit between data sectors
// R5: any reset terminates a running transported command
// R6: no trace of the terminated command afterwards
// R7: command starts by writing key block to E0h
// R8: legacy log-write taskfile: D6h, E0h, command B0h
// R9: legacy result: 00h/50h ok, 04h/51h error
// R10: sectors to transfer returned in both outcomes
// R11: extended log-write taskfile: E0h, command 3Fh
// R12: extended result: code low/high, then sector count
// R13: extended previous-half result registers read reserved
// R14: key block 256 words, action then function
// R15: action codes one to five decoded, rest refused
// R16: unknown action answers invalid-action status code
// R17: data phase moves through page E1h only
// R18: data page without command fails with 000Bh
// R19: key words little-endian, low byte first
// R20: long sector access completes with error response
package sct_pkg;
   // register word indices on the bus
   localparam logic [2:0]  OFS_TASKFILE  = 3'h0;
   localparam logic [2:0]  OFS_KEY       = 3'h1;
   localparam logic [2:0]  OFS_RESP_TF   = 3'h2;
   localparam logic [2:0]  OFS_RESP_LBA  = 3'h3;
   localparam logic [2:0]  OFS_RESP_HOB  = 3'h4;
   localparam logic [2:0]  OFS_STATE     = 3'h5;
   // taskfile word layout
   localparam int          TF_CMD_LSB    = 0;
   localparam int          TF_FEAT_LSB   = 8;
   localparam int          TF_PAGE_LSB   = 16;
   localparam int          TF_CNT_LSB    = 24;
   // state word layout
   localparam int          ST_LOAD_BIT   = 0;
   localparam int          ST_DATA_BIT   = 1;
   localparam int          ST_EXT_BIT    = 2;
   localparam int          ST_CNT_LSB    = 16;
   // command and log page codes
   localparam logic [7:0]  CMD_SMART     = 8'hb0;
   localparam logic [7:0]  CMD_WLOG_EXT  = 8'h3f;
   localparam logic [7:0]  CMD_RLOG_EXT  = 8'h2f;
   localparam logic [7:0]  FEAT_LOG_RD   = 8'hd5;
   localparam logic [7:0]  FEAT_LOG_WR   = 8'hd6;
   localparam logic [7:0]  PAGE_KEY      = 8'he0;
   localparam logic [7:0]  PAGE_DATA     = 8'he1;
   // result bytes
   localparam logic [7:0]  STAT_OK       = 8'h50;
   localparam logic [7:0]  STAT_ERR      = 8'h51;
   localparam logic [7:0]  ERR_NONE      = 8'h00;
   localparam logic [7:0]  ERR_ABORT     = 8'h04;
   // extended status codes
   localparam logic [15:0] XS_OK         = 16'h0000;
   localparam logic [15:0] XS_CNT_OVF    = 16'h0003;
   localparam logic [15:0] XS_NO_KEY     = 16'h000b;
   localparam logic [15:0] XS_BAD_ACTION = 16'h0010;
   // action codes
   localparam logic [15:0] ACT_LONG      = 16'h0001;
   localparam logic [15:0] ACT_WR_SAME   = 16'h0002;
   localparam logic [15:0] ACT_ERC       = 16'h0003;
   localparam logic [15:0] ACT_FEATURES  = 16'h0004;
   localparam logic [15:0] ACT_TABLE     = 16'h0005;
   // key block
   localparam int          KEY_WORDS_DEF = 256;
   localparam int          KEY_IDX_ACT   = 0;
   localparam int          KEY_IDX_FUNC  = 1;
   localparam int          KEY_IDX_SECS  = 2;

   typedef enum logic [1:0] {S_IDLE, S_LOAD, S_EXEC, S_DATA} phase_t;
endpackage

/* File: rtl/sct_action_decode.sv */
`timescale 1ns/1ps
// maps an action code onto support, data need and refusal code
module sct_action_decode (
   input  wire logic [15:0] action,
   output logic             supported,
   output logic             needs_data,
   output logic [15:0]      xs_code
);
   // long access, reserved and vendor codes all fall out as unsupported
   assign supported  = (action == sct_pkg::ACT_WR_SAME) ||
                       (action == sct_pkg::ACT_ERC) ||
                       (action == sct_pkg::ACT_FEATURES) ||
                       (action == sct_pkg::ACT_TABLE); // R15 R20
   // write-same sends data, data table returns it
   assign needs_data = (action == sct_pkg::ACT_WR_SAME) ||
                       (action == sct_pkg::ACT_TABLE); // R15
   assign xs_code    = supported ? sct_pkg::XS_OK : sct_pkg::XS_BAD_ACTION; // R16
endmodule // sct_action_decode

/* File: rtl/sct_command_transport.sv */
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module sct_command_transport #(
   parameter int KEY_WORDS = sct_pkg::KEY_WORDS_DEF
) (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        soft_rst,
   input  wire logic        hard_rst,
   input  wire logic        comreset,
   input  wire logic [2:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic      [31:0] readdata,
   output logic             waitrequest
);
   localparam int CNT_W = 9;

   // counter is nine bits and needs action, function and count words
   if (KEY_WORDS < 3 || KEY_WORDS > 512) begin : g_bad_key_words
      $error("KEY_WORDS must lie in 3..512");
   end

   sct_pkg::phase_t  phase_reg;
   sct_pkg::phase_t  phase_next;
   logic             wait_reg;
   logic [31:0]      rdata_reg;
   logic [31:0]      tf_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [15:0]      action_reg;
   logic [15:0]      func_reg;
   logic [15:0]      want_reg;
   logic [15:0]      left_reg;
   logic             ext_reg;
   logic [7:0]       err_reg;
   logic [7:0]       stat_reg;
   logic [15:0]      res_reg;
   logic [15:0]      sec_reg;
   logic             supported;
   logic             needs_data;
   logic [15:0]      xs_code;

   // bus handshake: one wait cycle, then a single acknowledge cycle
   wire        accept   = (read | write) & ~wait_reg;
   wire        wr_acc   = write & accept;
   wire        tf_wr    = wr_acc & (address == sct_pkg::OFS_TASKFILE);
   wire        key_wr   = wr_acc & (address == sct_pkg::OFS_KEY) &
                          (byteenable[1:0] == 2'h3) & (phase_reg == sct_pkg::S_LOAD);
   wire        ext_rst  = soft_rst | hard_rst | comreset;

   // taskfile image with byte lanes merged over the previous one
   wire [31:0] tf_in    = {byteenable[3] ? writedata[31:24] : tf_reg[31:24],
                           byteenable[2] ? writedata[23:16] : tf_reg[23:16],
                           byteenable[1] ? writedata[15:8]  : tf_reg[15:8],
                           byteenable[0] ? writedata[7:0]   : tf_reg[7:0]};
   wire [7:0]  tf_cmd   = tf_in[sct_pkg::TF_CMD_LSB  +: 8];
   wire [7:0]  tf_feat  = tf_in[sct_pkg::TF_FEAT_LSB +: 8];
   wire [7:0]  tf_page  = tf_in[sct_pkg::TF_PAGE_LSB +: 8];
   wire [7:0]  tf_cnt   = tf_in[sct_pkg::TF_CNT_LSB  +: 8];

   // command classification; anything else is an ordinary command
   wire        is_smart = (tf_cmd == sct_pkg::CMD_SMART);
   wire        log_wr   = (is_smart & (tf_feat == sct_pkg::FEAT_LOG_WR)) |
                          (tf_cmd == sct_pkg::CMD_WLOG_EXT); // R8 R11
   wire        log_rd   = (is_smart & (tf_feat == sct_pkg::FEAT_LOG_RD)) |
                          (tf_cmd == sct_pkg::CMD_RLOG_EXT);
   wire        key_issue = tf_wr & log_wr & (tf_page == sct_pkg::PAGE_KEY); // R7
   wire        data_acc = tf_wr & (log_wr | log_rd) &
                          (tf_page == sct_pkg::PAGE_DATA); // R17
   wire        plain_cmd = tf_wr & ~key_issue & ~data_acc; // R1 R4

   // key word accounting
   wire        key_last = key_wr & (cnt_reg == CNT_W'(KEY_WORDS - 1)); // R14
   wire        exec_now = (phase_reg == sct_pkg::S_EXEC);
   wire        in_data  = (phase_reg == sct_pkg::S_DATA);
   wire        data_fit = ({8'h00, tf_cnt} <= left_reg);
   wire [15:0] left_after = left_reg - {8'h00, tf_cnt};
   wire        go_data  = supported & needs_data & (want_reg != 16'h0000);

   // result selection for the command itself and for data page accesses
   wire        resp_set = exec_now | data_acc;
   wire        resp_ok  = exec_now ? supported : (in_data & data_fit);
   wire [15:0] resp_res = exec_now ? (supported ? func_reg : xs_code) :
                          (!in_data ? sct_pkg::XS_NO_KEY :
                          (data_fit ? sct_pkg::XS_OK : sct_pkg::XS_CNT_OVF)); // R16 R18
   wire [15:0] resp_sec = exec_now ? (go_data ? want_reg : 16'h0000) :
                          (!in_data ? 16'h0000 : (data_fit ? left_after : left_reg)); // R10

   // state word for software
   wire [31:0] state_word = {7'h00, cnt_reg, 12'h000, 1'b0, ext_reg, in_data,
                             phase_reg == sct_pkg::S_LOAD};

   // read mux; previous-half results read as zero, as do holes
   wire [31:0] rd_mux =
      (address == sct_pkg::OFS_TASKFILE) ? tf_reg :
      (address == sct_pkg::OFS_RESP_TF)  ? {16'h0000, stat_reg, err_reg} :
      (address == sct_pkg::OFS_RESP_LBA) ? {sec_reg, res_reg} : // R9 R12
      (address == sct_pkg::OFS_STATE)    ? state_word :
      32'h0000_0000; // R13

   sct_action_decode u_decode (
      .action     (action_reg),
      .supported  (supported),
      .needs_data (needs_data),
      .xs_code    (xs_code)
   );

   // phase sequencing
   always_comb begin
      phase_next = phase_reg;
      unique case (phase_reg)
         sct_pkg::S_IDLE: begin
            if (key_issue) begin
               phase_next = sct_pkg::S_LOAD;
            end
         end
         sct_pkg::S_LOAD: begin
            if (key_last) begin
               phase_next = sct_pkg::S_EXEC; // R14
            end
         end
         sct_pkg::S_EXEC: begin
            // exec lasts one cycle, so no bus accept can land in it
            phase_next = go_data ? sct_pkg::S_DATA : sct_pkg::S_IDLE; // R2
         end
         sct_pkg::S_DATA: begin
            if (key_issue) begin
               phase_next = sct_pkg::S_LOAD; // R1
            end else if (data_acc && data_fit && left_after == 16'h0000) begin
               phase_next = sct_pkg::S_IDLE;
            end
         end
      endcase
   end

   // bus slave flops; a write takes effect at the acknowledge edge
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wait_reg  <= 1'b1;
         rdata_reg <= 32'h0000_0000;
      end else begin
         wait_reg <= ~((read | write) & wait_reg);
         if (read && wait_reg) begin
            rdata_reg <= rd_mux;
         end
      end
   end

   // command progress; any link reset drops everything silently
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         phase_reg <= sct_pkg::S_IDLE;
         cnt_reg   <= '0;
         ext_reg   <= 1'b0;
         left_reg  <= 16'h0000;
         tf_reg    <= 32'h0000_0000;
      end else if (ext_rst) begin
         phase_reg <= sct_pkg::S_IDLE; // R5 R6
         cnt_reg   <= '0;
         ext_reg   <= 1'b0;
         left_reg  <= 16'h0000;
         tf_reg    <= 32'h0000_0000;
      end else begin
         phase_reg <= phase_next;
         if (tf_wr) begin
            tf_reg <= tf_in;
         end
         if (key_issue) begin
            cnt_reg <= '0;
            ext_reg <= ~is_smart;
         end else if (key_wr) begin
            cnt_reg <= cnt_reg + CNT_W'(1);
         end
         if (exec_now) begin
            left_reg <= go_data ? want_reg : 16'h0000;
         end else if (data_acc && in_data && data_fit) begin
            left_reg <= left_after; // R4
         end
      end
   end

   // key capture; low byte of each word is the lower-addressed byte
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         action_reg <= 16'h0000;
         func_reg   <= 16'h0000;
         want_reg   <= 16'h0000;
      end else if (ext_rst) begin
         action_reg <= 16'h0000;
         func_reg   <= 16'h0000;
         want_reg   <= 16'h0000;
      end else if (key_wr) begin
         if (cnt_reg == CNT_W'(sct_pkg::KEY_IDX_ACT)) begin
            action_reg <= writedata[15:0]; // R19
         end
         if (cnt_reg == CNT_W'(sct_pkg::KEY_IDX_FUNC)) begin
            func_reg <= writedata[15:0]; // R19
         end
         if (cnt_reg == CNT_W'(sct_pkg::KEY_IDX_SECS)) begin
            want_reg <= writedata[15:0]; // R19
         end
      end
   end

   // result registers; same bytes serve both issue styles
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         err_reg  <= 8'h00;
         stat_reg <= 8'h00;
         res_reg  <= 16'h0000;
         sec_reg  <= 16'h0000;
      end else if (ext_rst) begin
         err_reg  <= 8'h00; // R6
         stat_reg <= 8'h00;
         res_reg  <= 16'h0000;
         sec_reg  <= 16'h0000;
      end else if (resp_set) begin
         err_reg  <= resp_ok ? sct_pkg::ERR_NONE : sct_pkg::ERR_ABORT; // R9 R12
         stat_reg <= resp_ok ? sct_pkg::STAT_OK : sct_pkg::STAT_ERR; // R9 R12
         res_reg  <= resp_res;
         sec_reg  <= resp_sec; // R10
      end
   end

   assign readdata    = rdata_reg;
   assign waitrequest = wait_reg;

   a_wait_drop: assert property (@(posedge clk) disable iff (!arst_n)
      (read | write) && waitrequest |=> !waitrequest)
      else $error("request not acknowledged after one wait cycle");

   a_wait_pulse: assert property (@(posedge clk) disable iff (!arst_n)
      !waitrequest |=> waitrequest)
      else $error("acknowledge lasted more than one cycle");

   a_reset_clean: assert property (@(posedge clk) disable iff (!arst_n) // R5 R6
      ext_rst |=> phase_reg == sct_pkg::S_IDLE && stat_reg == 8'h00 &&
                  err_reg == 8'h00 && sec_reg == 16'h0000)
      else $error("link reset left command trace");

   a_hob_zero: assert property (@(posedge clk) disable iff (!arst_n) // R13
      read && waitrequest && address == sct_pkg::OFS_RESP_HOB
      |=> readdata == 32'h0000_0000)
      else $error("previous-half result not zero");

   a_bad_action: assert property (@(posedge clk) disable iff (!arst_n) // R16
      exec_now && !supported && !ext_rst
      |=> err_reg == sct_pkg::ERR_ABORT && stat_reg == sct_pkg::STAT_ERR &&
          res_reg == sct_pkg::XS_BAD_ACTION)
      else $error("unknown action not refused");

   a_long_reject: assert property (@(posedge clk) disable iff (!arst_n) // R20
      exec_now && action_reg == sct_pkg::ACT_LONG && !ext_rst
      |=> stat_reg == sct_pkg::STAT_ERR && phase_reg == sct_pkg::S_IDLE)
      else $error("long sector access not failed");

   a_nokey_data: assert property (@(posedge clk) disable iff (!arst_n) // R18
      data_acc && !in_data && !ext_rst
      |=> res_reg == sct_pkg::XS_NO_KEY && stat_reg == sct_pkg::STAT_ERR)
      else $error("data page without command not failed");

   a_plain_pass: assert property (@(posedge clk) disable iff (!arst_n) // R1 R4
      plain_cmd && in_data && !ext_rst
      |=> phase_reg == sct_pkg::S_DATA && $stable(left_reg))
      else $error("ordinary command disturbed data phase");

   a_key_length: assert property (@(posedge clk) disable iff (!arst_n) // R14
      key_last && !ext_rst |=> exec_now ##1 phase_reg != sct_pkg::S_LOAD)
      else $error("key block end not followed by decode");

   a_nodata_free: assert property (@(posedge clk) disable iff (!arst_n) // R2
      exec_now && !go_data && !ext_rst |=> phase_reg == sct_pkg::S_IDLE)
      else $error("no-data command left transfer pending");

   a_sec_report: assert property (@(posedge clk) disable iff (!arst_n) // R10
      exec_now && go_data && !ext_rst
      |=> sec_reg == $past(want_reg) && in_data && stat_reg == sct_pkg::STAT_OK)
      else $error("sector count not reported");

endmodule // sct_command_transport

/* File: test/host_model.sv */
`timescale 1ns/1ps
// host controller: one avalon request at a time, log commands on top
module host_model (
   input  wire logic        clk,
   input  wire logic        waitrequest,
   output logic      [2:0]  address,
   output logic             read,
   output logic             write,
   output logic      [31:0] writedata,
   output logic      [3:0]  byteenable
);
   initial begin
      address    = 3'h0;
      read       = 1'b0;
      write      = 1'b0;
      writedata  = 32'h0000_0000;
      byteenable = 4'hf;
   end

   // request held until the rising edge that samples waitrequest low
   task automatic xfer(input logic wr, input logic [2:0] a, input logic [31:0] d);
      @(posedge clk);
      address   <= a;
      read      <= !wr;
      write     <= wr;
      writedata <= d;
      do @(posedge clk); while (waitrequest !== 1'b0);
      read      <= 1'b0;
      write     <= 1'b0;
      writedata <= ~d; // a released bus keeps no stale data
   endtask

   // key block to page e0, then n words low byte in [7:0]
   task automatic key_block(input logic ext, input logic [15:0] act, fn, secs, input int n);
      xfer(1'b1, sct_pkg::OFS_TASKFILE, ext ?
           {8'h01, sct_pkg::PAGE_KEY, 8'h00, sct_pkg::CMD_WLOG_EXT} :
           {8'h01, sct_pkg::PAGE_KEY, sct_pkg::FEAT_LOG_WR, sct_pkg::CMD_SMART});
      for (int i = 0; i < n; i++) begin
         xfer(1'b1, sct_pkg::OFS_KEY, {16'h0000, (i == 0) ? act : (i == 1) ? fn :
              (i == 2) ? secs : 16'h0000});
      end
   endtask

   // data sectors always go through page e1
   task automatic data_xfer(input logic ext, rdir, input logic [7:0] cnt);
      xfer(1'b1, sct_pkg::OFS_TASKFILE, ext ?
           {cnt, sct_pkg::PAGE_DATA, 8'h00, rdir ? sct_pkg::CMD_RLOG_EXT : sct_pkg::CMD_WLOG_EXT} :
           {cnt, sct_pkg::PAGE_DATA, rdir ? sct_pkg::FEAT_LOG_RD : sct_pkg::FEAT_LOG_WR,
            sct_pkg::CMD_SMART});
   endtask
endmodule // host_model

/* File: test/sct_command_transport_test.sv */
`timescale 1ns/1ps
module sct_command_transport_test;
   localparam int          KW   = 4; // short key block keeps the run brief
   localparam logic [31:0] OKW  = {16'h0000, sct_pkg::STAT_OK, sct_pkg::ERR_NONE};
   localparam logic [31:0] ERW  = {16'h0000, sct_pkg::STAT_ERR, sct_pkg::ERR_ABORT};
   localparam logic [15:0] ACTS [10] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004,
                                         16'h0005, 16'h0006, 16'hbfff, 16'hc000, 16'hffff};
   logic        clk, arst_n, soft_rst, hard_rst, comreset;
   logic [2:0]  address;
   logic        read, write, waitrequest;
   logic [31:0] writedata, readdata;
   logic [3:0]  byteenable;
   logic [31:0] exp_q[$], msk_q[$];
   string       nm_q[$];
   int          error_cnt, total_checks, cycles;

   sct_command_transport #(.KEY_WORDS(KW)) DUT (.clk(clk), .arst_n(arst_n),
      .soft_rst(soft_rst), .hard_rst(hard_rst), .comreset(comreset), .address(address),
      .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest));
   host_model h (.clk(clk), .waitrequest(waitrequest), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic close_out();
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // note the expectation, then run the read
   task automatic rd(input string nm, input logic [2:0] a, input logic [31:0] e, m);
      nm_q.push_back(nm);
      exp_q.push_back(e);
      msk_q.push_back(m);
      h.xfer(1'b0, a, 32'h0000_0000);
   endtask

   // readdata taken at the same edge that samples waitrequest low
   always @(posedge clk) begin
      if (read === 1'b1 && waitrequest === 1'b0 && exp_q.size() > 0) begin
         chk(nm_q.pop_front(), readdata & msk_q.pop_front(), exp_q.pop_front());
      end
   end

   task automatic cmd_check(input logic ext, input logic [15:0] act, fn, secs, input logic fin);
      logic ok, dat;
      ok  = act >= 16'h0002 && act <= 16'h0005;
      dat = act == sct_pkg::ACT_WR_SAME || act == sct_pkg::ACT_TABLE;
      h.key_block(ext, act, fn, secs, KW);
      repeat (2) @(posedge clk);
      rd("resp_tf", sct_pkg::OFS_RESP_TF, ok ? OKW : ERW, '1);
      rd("resp_lba", sct_pkg::OFS_RESP_LBA, ok ? {dat ? secs : 16'h0000, fn} :
         {16'h0000, sct_pkg::XS_BAD_ACTION}, '1);
      rd("resp_hob", sct_pkg::OFS_RESP_HOB, 32'h0, '1);
      rd("state", sct_pkg::OFS_STATE, {29'h0, ext, ok && dat && secs != 0, 1'b0}, 32'h7);
      // host moves the whole data phase before its next command
      if (fin && ok && dat && secs != 16'h0000) begin
         dacc(ext, act == sct_pkg::ACT_TABLE, secs[7:0], 1'b1, 32'h0, '1);
      end
   endtask

   task automatic dacc(input logic ext, rdir, input logic [7:0] cnt, input logic ok,
                       input logic [31:0] lba, msk);
      h.data_xfer(ext, rdir, cnt);
      repeat (2) @(posedge clk);
      rd("data_tf", sct_pkg::OFS_RESP_TF, ok ? OKW : ERW, '1);
      rd("data_lba", sct_pkg::OFS_RESP_LBA, lba, msk);
   endtask

   // one reset source per kind, asserted for a single edge
   task automatic pulse(input int k);
      @(posedge clk);
      soft_rst <= k == 0;
      hard_rst <= k == 1;
      comreset <= k == 2;
      arst_n   <= k != 3;
      @(posedge clk);
      {soft_rst, hard_rst, comreset, arst_n} <= 4'b0001;
   endtask

   // hang guard, far above the expected run of under a thousand cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt++;
         close_out();
      end
   end

   initial begin
      void'($urandom(32'hcfc026d8));
      {arst_n, soft_rst, hard_rst, comreset} = 4'b0000;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      rd("tf_rst", sct_pkg::OFS_RESP_TF, 32'h0, '1);
      rd("state_rst", sct_pkg::OFS_STATE, 32'h0, '1);
      rd("unmapped", 3'h6, 32'h0, '1);
      // every listed action code, alternating between the two issue routes, then two random ones
      for (int i = 0; i < 12; i++) begin
         cmd_check(i[0], i < 10 ? ACTS[i] : 16'($urandom), 16'($urandom),
                   16'($urandom_range(1, 9)), 1'b1);
      end
      // data phase split by a plain command, with an overflow in the middle
      cmd_check(1'b0, sct_pkg::ACT_WR_SAME, 16'h0001, 16'h0005, 1'b0);
      dacc(1'b0, 1'b0, 8'h02, 1'b1, {16'h0003, 16'h0}, 32'hffff0000);
      h.xfer(1'b1, sct_pkg::OFS_TASKFILE, 32'h0100_00c8);
      dacc(1'b1, 1'b0, 8'h04, 1'b0, {16'h0, sct_pkg::XS_CNT_OVF}, 32'h0000ffff);
      dacc(1'b1, 1'b0, 8'h03, 1'b1, 32'h0, 32'hffff0000);
      dacc(1'b0, 1'b1, 8'h01, 1'b0, {16'h0, sct_pkg::XS_NO_KEY}, 32'h0000ffff);
      // a finished data phase leaves no access pending
      cmd_check(1'b1, sct_pkg::ACT_TABLE, 16'h0002, 16'h0004, 1'b1);
      cmd_check(1'b0, sct_pkg::ACT_ERC, 16'h0001, 16'h0002, 1'b1);
      dacc(1'b0, 1'b0, 8'h01, 1'b0, {16'h0, sct_pkg::XS_NO_KEY}, 32'h0000ffff);
      // every reset kind cuts a pending data phase, then a half-loaded block
      for (int k = 0; k < 8; k++) begin
         if (k[0]) begin
            h.key_block(1'b1, sct_pkg::ACT_ERC, 16'h0001, 16'h0000, 2);
         end else begin
            cmd_check(1'b0, sct_pkg::ACT_TABLE, 16'h0002, 16'h0003, 1'b0);
         end
         pulse(k / 2);
         rd("tf_cut", sct_pkg::OFS_RESP_TF, 32'h0, '1);
         rd("lba_cut", sct_pkg::OFS_RESP_LBA, 32'h0, '1);
         rd("state_cut", sct_pkg::OFS_STATE, 32'h0, '1);
         dacc(1'b1, 1'b0, 8'h01, 1'b0, {16'h0, sct_pkg::XS_NO_KEY}, 32'h0000ffff);
      end
      repeat (2) @(posedge clk);
      chk("unanswered", exp_q.size(), 32'h0);
      close_out();
   end
endmodule // sct_command_transport_test
